//--- rtl/cati_defs.svh
// Timing constants for the camera auxiliary trigger block
`ifndef CATI_DEFS_SVH
`define CATI_DEFS_SVH

`define CATI_CLK_MHZ        25
`define CATI_ECHO_US        6
`define CATI_ECHO_CYCLES    (`CATI_ECHO_US * `CATI_CLK_MHZ)

`endif

//--- rtl/cati_pkg.sv
// Types for the camera auxiliary trigger block
package cati_pkg;
    typedef enum logic [0:0] {
        CATI_ECHO_IDLE,
        CATI_ECHO_HIGH
    } cati_echo_state_t;
endpackage

//--- rtl/cati_aux_io.sv
// Camera auxiliary port trigger input and timing output logic
// What this block does
// R1 - Single-ended trigger falling edge starts exposure; rising edge does nothing.
// R2 - Differential trigger falling edge (p minus n) also starts exposure.
// R3 - Every external trigger start emits a 6 us positive echo pulse; a start during a pulse restarts its 6 us count instead.
// R4 - Echo pulse launches at the trigger's high-to-low transition.
// R5 - Strobe high exactly while sensor exposes in continuous overlapped mode.
// R6 - Line-valid high through the valid part of each line.
// R7 - Line-valid low in gaps between lines and frames.
// R8 - Frame-valid high over active lines, low between frames.
// R9 - Both triggers are synchronised; a fall on either, or on both in the same cycle, gives one event.
// R10 - Trigger source idles high and gives one clean fall per request.
`include "cati_defs.svh"
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser with a chosen reset level
module cati_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic pin_in,
    output logic      sync_out
);

    logic meta_r;

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            meta_r   <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta_r   <= pin_in;
            sync_out <= meta_r;
        end
    end

endmodule

// Falling-edge detector on a synchronised level
module cati_fall_det (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic level_in,
    output logic      fall_out
);

    logic prev_r;

    // Resets high so an idle-high line gives no false edge
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            prev_r <= 1'b1;
        end else begin
            prev_r <= level_in;
        end
    end

    always_comb begin
        fall_out = prev_r & ~level_in;
    end

endmodule

module cati_aux_io #(
    parameter int ECHO_CYCLES = `CATI_ECHO_CYCLES
) (
    input  wire logic clk_in,
    input  wire logic sys_rst_in,
    input  wire logic trig_se_in,
    input  wire logic trig_diff_p_in,
    input  wire logic trig_diff_n_in,
    input  wire logic overlap_mode_in,
    input  wire logic sensor_exposing_in,
    input  wire logic line_active_in,
    input  wire logic frame_active_in,
    output logic      exposure_start_out,
    output logic      trigger_echo_out,
    output logic      strobe_out,
    output logic      line_valid_out,
    output logic      frame_valid_out
);

    localparam int CW = $clog2(ECHO_CYCLES + 1);

    localparam logic SE_IDLE = 1'b1;
    localparam logic P_IDLE  = 1'b1;
    localparam logic N_IDLE  = 1'b0;

    // Counter needs at least one cycle of pulse
    if (ECHO_CYCLES < 1) begin : g_bad_echo
        $error("ECHO_CYCLES must be at least 1");
    end

    logic                       se_sync;
    logic                       p_sync;
    logic                       n_sync;
    logic                       df_level;
    logic                       se_fall;
    logic                       df_fall;
    logic                       fall_nxt;
    logic [CW-1:0]              echo_cnt_r;
    cati_pkg::cati_echo_state_t echo_state_r;

    // Each pin passes two flops before any logic reads it
    cati_sync2 #(
        .RST_VAL (SE_IDLE)
    ) i_se_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (trig_se_in),          // [R9]
        .sync_out   (se_sync)
    );

    cati_sync2 #(
        .RST_VAL (P_IDLE)
    ) i_p_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (trig_diff_p_in),      // [R9]
        .sync_out   (p_sync)
    );

    cati_sync2 #(
        .RST_VAL (N_IDLE)
    ) i_n_sync (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .pin_in     (trig_diff_n_in),      // [R9]
        .sync_out   (n_sync)
    );

    // Differential level is high only while p is high and n low
    always_comb begin
        df_level = p_sync & ~n_sync;       // [R2]
    end

    // Falling edges only; rising edges give nothing
    cati_fall_det i_se_fall (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .level_in   (se_sync),             // [R1]
        .fall_out   (se_fall)
    );

    cati_fall_det i_df_fall (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .level_in   (df_level),            // [R2]
        .fall_out   (df_fall)
    );

    // Simultaneous falls on both inputs give one event
    always_comb begin
        fall_nxt = se_fall | df_fall;      // [R1] [R2] [R9]
    end

    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            exposure_start_out <= 1'b0;
        end else begin
            exposure_start_out <= fall_nxt;                 // [R1] [R2]
        end
    end

    // Echo pulse; a new fall during the pulse restarts it
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            echo_state_r     <= cati_pkg::CATI_ECHO_IDLE;
            echo_cnt_r       <= '0;
            trigger_echo_out <= 1'b0;
        end else begin
            case (echo_state_r)
                cati_pkg::CATI_ECHO_IDLE: begin
                    if (fall_nxt) begin
                        echo_state_r     <= cati_pkg::CATI_ECHO_HIGH;  // [R4]
                        echo_cnt_r       <= CW'(ECHO_CYCLES - 1);      // [R3]
                        trigger_echo_out <= 1'b1;
                    end
                end
                cati_pkg::CATI_ECHO_HIGH: begin
                    if (fall_nxt) begin
                        echo_cnt_r <= CW'(ECHO_CYCLES - 1);            // [R3]
                    end else if (echo_cnt_r == '0) begin
                        echo_state_r     <= cati_pkg::CATI_ECHO_IDLE;
                        trigger_echo_out <= 1'b0;                      // [R3]
                    end else begin
                        echo_cnt_r <= echo_cnt_r - 1'b1;
                    end
                end
                default: begin
                    echo_state_r     <= cati_pkg::CATI_ECHO_IDLE;
                    trigger_echo_out <= 1'b0;
                end
            endcase
        end
    end

    // Strobe follows actual exposure in overlapped mode only
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            strobe_out <= 1'b0;
        end else begin
            strobe_out <= overlap_mode_in & sensor_exposing_in;  // [R5]
        end
    end

    // Line and frame valid; line valid forced low outside a frame
    always_ff @(posedge clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_valid_out  <= 1'b0;
            frame_valid_out <= 1'b0;
        end else begin
            line_valid_out  <= line_active_in & frame_active_in;  // [R6] [R7]
            frame_valid_out <= frame_active_in;                   // [R8]
        end
    end

endmodule

`default_nettype wire

//--- dv/cati_src.sv
// Trigger source model
`timescale 1ns/10ps
`default_nettype none
module cati_src (
    input  wire logic clk_in, se_req_in, df_req_in,
    output logic      se_out = 1'h1, p_out = 1'h1, n_out = 1'h0
);
    always @(posedge clk_in) {se_out, p_out, n_out} <= {!se_req_in, !df_req_in, df_req_in};
endmodule
`default_nettype wire

//--- dv/cati_properties.sv
// Trigger block port checks
`timescale 1ns/10ps
`default_nettype none
module cati_chk #(parameter int ECHO_CYCLES = 150) (
    input wire logic clk_in, sys_rst_in, trig_se_in, trig_diff_p_in, trig_diff_n_in, overlap_mode_in,
    input wire logic sensor_exposing_in, line_active_in, frame_active_in, exposure_start_out,
    input wire logic trigger_echo_out, strobe_out, line_valid_out, frame_valid_out);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence start_lag; ##3 exposure_start_out; endsequence
    se_fall_a: assert property ($fell(trig_se_in) |-> start_lag) else $error("se");
    df_fall_a: assert property ($fell(trig_diff_p_in & ~trig_diff_n_in) |-> start_lag) else $error("df");
    echo_len_a: assert property ($fell(trigger_echo_out) |-> $past(exposure_start_out, ECHO_CYCLES))
        else $error("len");
    echo_rise_a: assert property ($rose(trigger_echo_out) |-> exposure_start_out) else $error("rise");
    one_start_a: assert property (exposure_start_out |=> !exposure_start_out) else $error("dup");
    strobe_lvl_a: assert property (1 |=> strobe_out == $past(overlap_mode_in & sensor_exposing_in))
        else $error("sb");
    line_lvl_a: assert property (1 |=> line_valid_out == $past(line_active_in & frame_active_in))
        else $error("lv");
    frame_lvl_a: assert property (1 |=> frame_valid_out == $past(frame_active_in)) else $error("fv");
endmodule
bind cati_aux_io cati_chk #(.ECHO_CYCLES(ECHO_CYCLES)) i_chk (.*);
`default_nettype wire

//--- dv/camera_aux_trigger_io_bench.sv
// Trigger block bench
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin errors++; $display("CHECK FAILED %s %h %h", n, e, s); end end
module camera_aux_trigger_io_bench;
    logic clk_in = 1'h0, sys_rst_in = 1'h1, sr = 1'h0, dr = 1'h0, trig_se_in, trig_diff_p_in, trig_diff_n_in;
    logic overlap_mode_in = 1'h0, sensor_exposing_in = 1'h0, line_active_in = 1'h0, frame_active_in = 1'h0;
    logic exposure_start_out, trigger_echo_out, strobe_out, line_valid_out, frame_valid_out;
    logic [7:0] ns;
    int errors = 0, n_tests = 0;
    localparam int ECHO = 4;
    always #20 clk_in = ~clk_in;
    cati_src i_src (.clk_in, .se_req_in(sr), .df_req_in(dr), .se_out(trig_se_in), .p_out(trig_diff_p_in),
        .n_out(trig_diff_n_in));
    cati_aux_io #(.ECHO_CYCLES(ECHO)) i_dut (.*);
    task automatic t_reset;
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_in);
            #1;
            `CHK("rst_start", 1'h0, exposure_start_out)
            `CHK("rst_echo", 1'h0, trigger_echo_out)
            `CHK("rst_line", 1'h0, line_valid_out)
            `CHK("rst_frame", 1'h0, frame_valid_out)
        end
    endtask
    task automatic t_echo;
        logic [7:0] w;
        logic [7:0] lag;
        w = 8'h0;
        lag = 8'hff;
        @(posedge clk_in);
        sr <= 1'h1;
        for (int i = 0; i < 20; i++) begin
            @(posedge clk_in);
            if (i == 2) sr <= 1'h0;
            #1;
            if (exposure_start_out === 1'h1) lag = w;
            w += trigger_echo_out;
        end
        `CHK("echo_width", 8'(ECHO), w)
        `CHK("echo_at_start", 8'h0, lag)
    endtask
    task automatic t_levels;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_in);
            {overlap_mode_in, sensor_exposing_in, line_active_in, frame_active_in} <= 4'(i);
            @(posedge clk_in);
            #1;
            `CHK("strobe", i[3] & i[2], strobe_out)
            `CHK("line_valid", i[1] & i[0], line_valid_out)
            `CHK("frame_valid", i[0], frame_valid_out)
        end
    endtask
    task automatic t_trig(input logic d);
        ns = 8'h0;
        for (int i = 0; i < 12; i++) begin
            @(posedge clk_in);
            {sr, dr} <= {!d && i < 3, d && i < 3};
            {overlap_mode_in, sensor_exposing_in, line_active_in, frame_active_in} <= 4'(i + 5);
            #1 ns += exposure_start_out;
        end
        `CHK("starts", 8'h01, ns)
    endtask
    task automatic end_sim;
        $display("errors %0d of %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        sys_rst_in <= 1'h0;
        t_reset();
        t_trig(1'h0);
        t_trig(1'h1);
        t_echo();
        t_levels();
        end_sim();
    end
endmodule
`default_nettype wire
